// File: pkg/sacr_map.vh
`ifndef SACR_MAP_VH
`define SACR_MAP_VH
// Register offsets on the serial sub-address space
`define SACR_OFS_NEG_REF    8'h0a
`define SACR_OFS_POS_REF    8'h0b
`define SACR_OFS_POWER_CFG  8'h0c
`define SACR_OFS_RESET_CTL  8'h0e
`define SACR_OFS_GLOBAL_GAIN 8'h10
// Reset values
`define SACR_RST_NEG_REF    8'h76
`define SACR_RST_POS_REF    8'h80
`define SACR_RST_POWER_CFG  8'h00
`define SACR_RST_RESET_CTL  8'h00
`define SACR_RST_GLOBAL_GAIN 8'h00
// Implemented bits of each register
`define SACR_MASK_NEG_REF   8'hff
`define SACR_MASK_POS_REF   8'hff
`define SACR_MASK_POWER_CFG 8'h43
`define SACR_MASK_RESET_CTL 8'h07
`define SACR_MASK_GAIN      8'h3f
// Field positions
`define SACR_BIT_EXT_RES    6
`define SACR_BIT_BUS_TRI    1
`define SACR_BIT_STANDBY    0
`define SACR_BIT_SYNC_TRI   2
`define SACR_BIT_STATE_RST  1
`define SACR_BIT_SOFT_RST   0
// Gain step 0.12 in units of 1/256, rounded
`define SACR_GAIN_STEP_Q8   12'h01f
`define SACR_GAIN_UNITY_Q8  12'h100
// Sync timing: line values in pixel clocks, frame values in lines
`define SACR_LINE_TOTAL     10'h320
`define SACR_LINE_ACTIVE    10'h280
`define SACR_FRAME_TOTAL    10'h20d
`define SACR_FRAME_ACTIVE   10'h1e0
// Serial device address, value arbitrary
`define SACR_DEV_ADDR       7'h33
`endif

// File: design/sacr_gain_unit.v
`default_nettype none
`include "sacr_map.vh"
module sacr_gain_unit (
	input  wire        mclk_in,
	input  wire        rst_n_in,
	input  wire        clear_in,
	input  wire        hold_in,
	input  wire [5:0]  gain_code_in,
	input  wire [9:0]  pix_in,
	output reg  [9:0]  pix_out
);
	wire [11:0] factor;
	wire [21:0] product;
	wire [13:0] scaled;

	// Factor is 1 + 0.12 * code in eight fractional bits
	assign factor  = `SACR_GAIN_UNITY_Q8 + (`SACR_GAIN_STEP_Q8 * {6'h00, gain_code_in});
	assign product = {12'h000, pix_in} * {10'h000, factor};
	assign scaled  = product[21:8];

	////////////////////////////////////////////////////////////////////////////
	// Saturate rather than wrap, so bright pixels clip instead of going dark
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pix_out <= 10'h000;
		end else if (clear_in) begin
			pix_out <= 10'h000;
		end else if (!hold_in) begin
			pix_out <= (|scaled[13:10]) ? 10'h3ff : scaled[9:0];
		end
	end
endmodule // sacr_gain_unit
`default_nettype wire

// File: design/sacr_i2c_slave.v
`default_nettype none
`include "sacr_map.vh"
module sacr_i2c_slave (
	input  wire        mclk_in,
	input  wire        rst_n_in,
	input  wire        scl_in,
	input  wire        sda_in,
	output wire        sda_out,
	output reg         sda_oe_out,
	input  wire [7:0]  rdata_in,
	output reg  [7:0]  addr_out,
	output reg  [7:0]  wdata_out,
	output reg         wr_stb_out
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_ADDR  = 3'h1;
	localparam ST_ACK   = 3'h2;
	localparam ST_WRITE = 3'h3;
	localparam ST_READ  = 3'h4;
	localparam ST_RACK  = 3'h5;

	reg [1:0] scl_sync;
	reg [1:0] sda_sync;
	reg       scl_d;
	reg       sda_d;
	reg [2:0] state;
	reg [3:0] bitcnt;
	reg [7:0] shreg;
	reg       is_read;
	reg       have_sub;
	wire      scl_rise;
	wire      scl_fall;
	wire      start_cond;
	wire      stop_cond;

	// Open-drain: only ever pull low
	assign sda_out = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers; edges are taken from the second stage only
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_d    <= 1'b1;
			sda_d    <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_d    <= scl_sync[1];
			sda_d    <= sda_sync[1];
		end
	end

	assign scl_rise   = scl_sync[1] & ~scl_d;
	assign scl_fall   = ~scl_sync[1] & scl_d;
	assign start_cond = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
	assign stop_cond  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

	////////////////////////////////////////////////////////////////////////////
	// Byte engine: first byte after address sets the pointer, later ones write
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state      <= ST_IDLE;
			bitcnt     <= 4'h0;
			shreg      <= 8'h00;
			is_read    <= 1'b0;
			have_sub   <= 1'b0;
			sda_oe_out <= 1'b0;
			addr_out   <= 8'h00;
			wdata_out  <= 8'h00;
			wr_stb_out <= 1'b0;
		end else begin
			wr_stb_out <= 1'b0;
			if (start_cond) begin
				state      <= ST_ADDR;
				bitcnt     <= 4'h0;
				have_sub   <= 1'b0;
				sda_oe_out <= 1'b0;
			end else if (stop_cond) begin
				state      <= ST_IDLE;
				sda_oe_out <= 1'b0;
			end else begin
				case (state)
				ST_ADDR, ST_WRITE: begin
					if (scl_rise) begin
						shreg  <= {shreg[6:0], sda_sync[1]};
						bitcnt <= bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == 4'h8) begin
						sda_oe_out <= 1'b1;
						state      <= ST_ACK;
						if (state == ST_ADDR) begin
							is_read <= shreg[0];
							if (shreg[7:1] != `SACR_DEV_ADDR) begin
								sda_oe_out <= 1'b0;
								state      <= ST_IDLE;
							end
						end else if (!have_sub) begin
							addr_out <= shreg;
							have_sub <= 1'b1;
						end else begin
							wdata_out  <= shreg;
							wr_stb_out <= 1'b1;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bitcnt <= 4'h0;
						if (is_read) begin
							shreg      <= rdata_in;
							sda_oe_out <= ~rdata_in[7];
							state      <= ST_READ;
						end else begin
							sda_oe_out <= 1'b0;
							state <= ST_WRITE;
						end
					end
				end
				ST_READ: begin
					if (scl_rise) begin
						bitcnt <= bitcnt + 4'h1;
					end else if (scl_fall) begin
						if (bitcnt == 4'h8) begin
							sda_oe_out <= 1'b0;
							addr_out   <= addr_out + 8'h01;
							state      <= ST_RACK;
						end else begin
							shreg      <= {shreg[6:0], 1'b0};
							sda_oe_out <= ~shreg[6];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise && sda_sync[1]) begin
						state <= ST_IDLE;
					end else if (scl_fall) begin
						bitcnt     <= 4'h0;
						shreg      <= rdata_in;
						sda_oe_out <= ~rdata_in[7];
						state      <= ST_READ;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
				// Pointer steps after each written byte
				if (wr_stb_out) begin
					addr_out <= addr_out + 8'h01;
				end
			end
		end
	end
endmodule // sacr_i2c_slave
`default_nettype wire

// File: design/sacr_top.v
// Notes on behaviour
// - The negative reference code is 8 bits, code zero giving 0V and each step adding 5mV.
// - The positive reference code is 8 bits, code zero giving 2.5V and each step taking 5mV.
// - After reset the reference codes give 1.9V positive and 0.6V negative.
// - Power configuration bit 6 picks the external bias resistor when set, internal when clear.
// - Power configuration bit 1 set floats the 10-bit pixel bus, clear drives it.
// - Power configuration bit 0 set over the serial port puts the device in standby.
// - Reset control bit 2 set floats the frame start, vertical and horizontal syncs.
// - Reset control bit 1 set returns only the internal non-programmable state to default.
// - Reset control bit 0 set returns every register except reset control itself to its default.
// - Both reset bits hold the device in reset until the host writes them back to zero.
// - One global gain of 1 plus 0.12 times the 6-bit code applies to every pixel.
`default_nettype none
`include "sacr_map.vh"
module sacr_top (
	input  wire        mclk_in,
	input  wire        rst_n_in,
	input  wire        scl_in,
	input  wire        sda_in,
	output wire        sda_out,
	output wire        sda_oe_out,
	input  wire [9:0]  pix_in,
	output wire [9:0]  pix_data_out,
	output wire        pix_data_oe_out,
	output reg         frame_start_out,
	output reg         vertical_sync_out,
	output reg         horizontal_sync_out,
	output wire        sync_oe_out,
	output wire [7:0]  neg_ref_code_out,
	output wire [7:0]  pos_ref_code_out,
	output wire [5:0]  overall_gain_code_out,
	output wire        bias_resistor_pin_out,
	output wire        standby_out,
	output wire        state_reset_out
);
	reg  [7:0] negative_reference_code;
	reg  [7:0] positive_reference_code;
	reg  [7:0] power_configuration;
	reg  [7:0] reset_control;
	reg  [7:0] global_gain;
	reg  [7:0] next_rdata;
	reg  [9:0] col_count;
	reg  [9:0] row_count;
	wire [7:0] bus_addr;
	wire [7:0] bus_wdata;
	wire       bus_wr;
	wire       soft_reset;
	wire       hold_state;
	wire       standby;
	wire       line_end;
	wire       frame_end;

	////////////////////////////////////////////////////////////////////////////
	// Serial register port
	sacr_i2c_slave u_port (
		.mclk_in    (mclk_in),
		.rst_n_in   (rst_n_in),
		.scl_in     (scl_in),
		.sda_in     (sda_in),
		.sda_out    (sda_out),
		.sda_oe_out (sda_oe_out),
		.rdata_in   (next_rdata),
		.addr_out   (bus_addr),
		.wdata_out  (bus_wdata),
		.wr_stb_out (bus_wr)
	);

	// Reset bits are levels, so the device stays held until they are cleared
	assign soft_reset = reset_control[`SACR_BIT_SOFT_RST];
	assign hold_state = soft_reset | reset_control[`SACR_BIT_STATE_RST];
	assign standby    = power_configuration[`SACR_BIT_STANDBY];

	////////////////////////////////////////////////////////////////////////////
	// User registers; soft reset forces them to defaults while it is set.
	// The reset control register itself keeps its value, otherwise the host
	// could never see or release the reset it asked for.
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			negative_reference_code <= `SACR_RST_NEG_REF;
			positive_reference_code <= `SACR_RST_POS_REF;
			power_configuration     <= `SACR_RST_POWER_CFG;
			global_gain             <= `SACR_RST_GLOBAL_GAIN;
		end else if (soft_reset) begin
			negative_reference_code <= `SACR_RST_NEG_REF;
			positive_reference_code <= `SACR_RST_POS_REF;
			power_configuration     <= `SACR_RST_POWER_CFG;
			global_gain             <= `SACR_RST_GLOBAL_GAIN;
		end else if (bus_wr) begin
			case (bus_addr)
			`SACR_OFS_NEG_REF: begin
				negative_reference_code <= bus_wdata & `SACR_MASK_NEG_REF;
			end
			`SACR_OFS_POS_REF: begin
				positive_reference_code <= bus_wdata & `SACR_MASK_POS_REF;
			end
			`SACR_OFS_POWER_CFG: begin
				power_configuration <= bus_wdata & `SACR_MASK_POWER_CFG;
			end
			`SACR_OFS_GLOBAL_GAIN: begin
				global_gain <= bus_wdata & `SACR_MASK_GAIN;
			end
			default: begin
				global_gain <= global_gain;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset control is always writable so the host can release a held reset
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reset_control <= `SACR_RST_RESET_CTL;
		end else if (bus_wr && bus_addr == `SACR_OFS_RESET_CTL) begin
			reset_control <= bus_wdata & `SACR_MASK_RESET_CTL;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read-back multiplexer; unmapped offsets read as zero
	always @* begin
		case (bus_addr)
		`SACR_OFS_NEG_REF:     next_rdata = negative_reference_code;
		`SACR_OFS_POS_REF:     next_rdata = positive_reference_code;
		`SACR_OFS_POWER_CFG:   next_rdata = power_configuration;
		`SACR_OFS_RESET_CTL:   next_rdata = reset_control;
		`SACR_OFS_GLOBAL_GAIN: next_rdata = global_gain;
		default:               next_rdata = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Analog controls straight from the registers
	assign neg_ref_code_out      = negative_reference_code;
	assign pos_ref_code_out      = positive_reference_code;
	assign bias_resistor_pin_out = power_configuration[`SACR_BIT_EXT_RES];
	assign overall_gain_code_out = global_gain[5:0];
	assign standby_out           = standby;
	assign state_reset_out       = hold_state;

	////////////////////////////////////////////////////////////////////////////
	// Scan position counters: internal, non-programmable state
	assign line_end  = (col_count == `SACR_LINE_TOTAL - 10'h001);
	assign frame_end = (row_count == `SACR_FRAME_TOTAL - 10'h001);

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			col_count <= 10'h000;
			row_count <= 10'h000;
		end else if (hold_state) begin
			col_count <= 10'h000;
			row_count <= 10'h000;
		end else if (!standby) begin
			col_count <= line_end ? 10'h000 : col_count + 10'h001;
			if (line_end) begin
				row_count <= frame_end ? 10'h000 : row_count + 10'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sync outputs registered; they freeze low in reset and hold in standby
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frame_start_out     <= 1'b0;
			vertical_sync_out   <= 1'b0;
			horizontal_sync_out <= 1'b0;
		end else if (hold_state) begin
			frame_start_out     <= 1'b0;
			vertical_sync_out   <= 1'b0;
			horizontal_sync_out <= 1'b0;
		end else if (!standby) begin
			frame_start_out     <= (row_count == 10'h000) && (col_count == 10'h000);
			vertical_sync_out   <= (row_count < `SACR_FRAME_ACTIVE);
			horizontal_sync_out <= (col_count < `SACR_LINE_ACTIVE);
		end
	end

	assign sync_oe_out = ~reset_control[`SACR_BIT_SYNC_TRI];

	////////////////////////////////////////////////////////////////////////////
	// Pixel path: global gain, cleared under reset, frozen in standby
	sacr_gain_unit u_gain (
		.mclk_in      (mclk_in),
		.rst_n_in     (rst_n_in),
		.clear_in     (hold_state),
		.hold_in      (standby),
		.gain_code_in (global_gain[5:0]),
		.pix_in       (pix_in),
		.pix_out      (pix_data_out)
	);

	// Bus float is immediate so a shared bus is freed without waiting a line
	assign pix_data_oe_out = ~power_configuration[`SACR_BIT_BUS_TRI];
endmodule // sacr_top
`default_nettype wire

// File: test/sacr_i2c_host.sv
`default_nettype none
`include "sacr_map.vh"
module sacr_i2c_host (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output var  logic scl_out,
	output var  logic sda_low_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Bus idles released, pulled high
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	////////////////////////////////////////
	// Pins move 1 ns after an edge so the 2-FF sync never races them
	task automatic tk(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// 8 mclk low, 8 high: double the 4 mclk floor so the 3 mclk ACK lag fits
	task automatic bit_x(input logic b, output logic r);
		sda_low_out = !b;
		tk(6);
		scl_out = 1'b1;
		tk(6);
		r = sda_in;
		tk(2);
		scl_out = 1'b0;
		tk(2);
	endtask
	// Also serves as repeated start
	task automatic start;
		sda_low_out = 1'b0;
		tk(4);
		scl_out = 1'b1;
		tk(8);
		sda_low_out = 1'b1;
		tk(8);
		scl_out = 1'b0;
		tk(4);
	endtask
	task automatic stop;
		sda_low_out = 1'b1;
		tk(4);
		scl_out = 1'b1;
		tk(8);
		sda_low_out = 1'b0;
		tk(8);
	endtask
	// MSB first, ninth bit is the acknowledge slot
	task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		bit_x(1'b1, ack);
	endtask
	// ok low when any byte went unanswered
	task automatic wr(input logic [6:0] dev, input logic [7:0] sub, input logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		logic       a0, a1, a2;
		start();
		byte_x({dev, 1'b0}, q, a0);
		byte_x(sub, q, a1);
		byte_x(d, q, a2);
		stop();
		ok = !(a0 | a1 | a2);
	endtask
	// Single byte read, master NACK ends it
	task automatic rd(input logic [7:0] sub, output logic [7:0] d);
		logic a;
		start();
		byte_x({`SACR_DEV_ADDR, 1'b0}, d, a);
		byte_x(sub, d, a);
		start();
		byte_x({`SACR_DEV_ADDR, 1'b1}, d, a);
		byte_x(8'hff, d, a);
		stop();
	endtask
endmodule // sacr_i2c_host
`default_nettype wire

// File: test/sacr_top_chk.sv
`default_nettype none
module sacr_top_chk (
	input wire logic       mclk_in,
	input wire logic       rst_n_in,
	input wire logic       sda_oe_out,
	input wire logic [9:0] pix_in,
	input wire logic [9:0] pix_data_out,
	input wire logic       pix_data_oe_out,
	input wire logic       frame_start_out,
	input wire logic       vertical_sync_out,
	input wire logic       horizontal_sync_out,
	input wire logic       sync_oe_out,
	input wire logic [7:0] neg_ref_code_out,
	input wire logic [7:0] pos_ref_code_out,
	input wire logic [5:0] overall_gain_code_out,
	input wire logic       bias_resistor_pin_out,
	input wire logic       standby_out,
	input wire logic       state_reset_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	////////////////////////////////////////
	// Step is 31/256 of unity; clips at full scale rather than wrapping
	function automatic logic [9:0] gained(input logic [9:0] p, input logic [5:0] g);
		logic [21:0] m;
		m = (22'(p) * (22'(g) * 22'h1f + 22'h100)) >> 8;
		return (m > 22'h3ff) ? 10'h3ff : m[9:0];
	endfunction
	sequence s_live;
		!standby_out && !state_reset_out;
	endsequence
	sequence s_quiet;
		pix_data_out == 10'h000 && !frame_start_out && !vertical_sync_out && !horizontal_sync_out;
	endsequence
	sequence s_held;
		state_reset_out [*8];
	endsequence
	a_ref_defaults: assert property ($rose(rst_n_in) |->
		neg_ref_code_out == 8'h76 && pos_ref_code_out == 8'h80)
		else $error("reference codes off default after reset");
	a_ctl_defaults: assert property ($rose(rst_n_in) |->
		pix_data_oe_out && sync_oe_out && !bias_resistor_pin_out && !standby_out)
		else $error("control outputs off default after reset");
	a_gain_formula: assert property (s_live |=>
		pix_data_out == gained($past(pix_in), $past(overall_gain_code_out)))
		else $error("pixel gain wrong");
	a_standby_freeze: assert property (standby_out && !state_reset_out |=>
		$stable({pix_data_out, frame_start_out, vertical_sync_out, horizontal_sync_out}))
		else $error("outputs moved in standby");
	a_reset_clears: assert property (state_reset_out |=> s_quiet)
		else $error("outputs not cleared in reset");
	a_reset_holds: assert property ($rose(state_reset_out) |-> s_held)
		else $error("reset cleared itself");
	a_oe_on_write: assert property ($changed({pix_data_oe_out, sync_oe_out}) |->
		sda_oe_out)
		else $error("enable moved without a write");
	a_code_on_write: assert property ($changed({neg_ref_code_out, pos_ref_code_out,
		overall_gain_code_out, bias_resistor_pin_out, standby_out}) |-> sda_oe_out)
		else $error("register moved without a write");
endmodule // sacr_top_chk
bind sacr_top sacr_top_chk sacr_top_chk_i (.*);
`default_nettype wire

// File: test/test_sensor_analog_control_regs.sv
`default_nettype none
`include "sacr_map.vh"
module test_sensor_analog_control_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic       mclk = 1'b0;
	logic       rst_n = 1'b0;
	logic [9:0] pix = 10'h000;
	logic [9:0] pdo;
	logic [7:0] nref, pref, rb;
	logic [5:0] gcode;
	logic       scl, hlow, doe, dsd, pdoe, fs, vs, hs, soe, bias, sby, srst, ok;
	logic       sda;
	int         fail_count = 0;
	int         checked = 0;
	int         cycles = 0;
	logic [7:0] ofs [5] = '{8'h0a, 8'h0b, 8'h0c, 8'h0e, 8'h10};
	logic [7:0] dfl [5] = '{8'h76, 8'h80, 8'h00, 8'h00, 8'h00};
	// Open-drain wire with pull-up
	assign sda = !hlow && !(doe && !dsd);
	sacr_top sacr_top_i (.mclk_in(mclk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda),
		.sda_out(dsd), .sda_oe_out(doe), .pix_in(pix), .pix_data_out(pdo),
		.pix_data_oe_out(pdoe), .frame_start_out(fs), .vertical_sync_out(vs),
		.horizontal_sync_out(hs), .sync_oe_out(soe), .neg_ref_code_out(nref),
		.pos_ref_code_out(pref), .overall_gain_code_out(gcode),
		.bias_resistor_pin_out(bias), .standby_out(sby), .state_reset_out(srst));
	sacr_i2c_host sacr_i2c_host_i (.clk_in(mclk), .sda_in(sda), .scl_out(scl),
		.sda_low_out(hlow));
	initial forever #20 mclk = !mclk;
	////////////////////////////////////////
	// Run is about 15k cycles; the ceiling leaves room
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			fail_count++;
			summarize();
		end
	end
	task automatic summarize;
		if (fail_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic put(input logic [7:0] sub, input logic [7:0] d);
		sacr_i2c_host_i.wr(`SACR_DEV_ADDR, sub, d, ok);
		chk({9'h000, ok}, 10'h001);
	endtask
	task automatic get(input logic [7:0] sub, input logic [7:0] exp);
		sacr_i2c_host_i.rd(sub, rb);
		chk({2'b00, rb}, {2'b00, exp});
	endtask
	// Output is settled well after the one-cycle latency
	task automatic pixel(input logic [9:0] p, input logic [9:0] exp);
		pix = p;
		repeat (3) @(posedge mclk);
		#1;
		chk(pdo, exp);
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		for (int i = 0; i < 5; i++)
			get(ofs[i], dfl[i]);
		chk({2'b00, nref}, 10'h076);
		chk({2'b00, pref}, 10'h080);
		chk({6'h00, pdoe, soe, bias, sby}, 10'h00c);
		// Factory and unused bits drop; standby holds the pixel output
		put(8'h0c, 8'hff);
		get(8'h0c, 8'h43);
		chk({6'h00, pdoe, soe, bias, sby}, 10'h007);
		pixel(10'h2aa, 10'h000);
		put(8'h0c, 8'h00);
		// Unmapped offset and foreign address leave state alone
		sacr_i2c_host_i.wr(`SACR_DEV_ADDR, 8'h0d, 8'hff, ok);
		sacr_i2c_host_i.wr(`SACR_DEV_ADDR ^ 7'h01, 8'h10, 8'h3f, ok);
		chk({9'h000, ok}, 10'h000);
		get(8'h10, 8'h00);
		get(8'h0c, 8'h00);
		put(8'h10, 8'h55);
		get(8'h10, 8'h15);
		pixel(10'h064, 10'h162);
		put(8'h10, 8'h3f);
		pixel(10'h064, 10'h35e);
		pixel(10'h0c8, 10'h3ff);
		put(8'h10, 8'h00);
		pixel(10'h2aa, 10'h2aa);
		// 0.4 V and 2.1 V keep the span centred
		put(8'h0a, 8'h50);
		put(8'h0b, 8'h50);
		chk({nref, pref[1:0]}, 10'h140);
		get(8'h0b, 8'h50);
		put(8'h0e, 8'h04);
		chk({9'h000, soe}, 10'h000);
		put(8'h0e, 8'h02);
		pixel(10'h123, 10'h000);
		chk({nref, soe, srst}, 10'h143);
		put(8'h0e, 8'h00);
		chk({9'h000, srst}, 10'h000);
		// Scan restarts at row 0 on release, a few dozen columns in by now
		chk({7'h00, fs, vs, hs}, 10'h003);
		put(8'h10, 8'h3f);
		put(8'h0e, 8'h01);
		chk({nref, gcode[1:0]}, 10'h1d8);
		chk({2'b00, pref}, 10'h080);
		get(8'h0e, 8'h01);
		put(8'h0e, 8'h00);
		chk({9'h000, srst}, 10'h000);
		get(8'h10, 8'h00);
		summarize();
	end
endmodule // test_sensor_analog_control_regs
`default_nettype wire
